// ==== design/adc_fmt_cfg.svh ====
`ifndef ADC_FMT_CFG_SVH
`define ADC_FMT_CFG_SVH

// register byte offsets
`define OFS_CONTROL 12'h000
`define OFS_RES_HIGH 12'h004
`define OFS_RES_LOW 12'h008
`define OFS_ANALOG_SEL 12'h00C
`define OFS_IRQ_EN 12'h010
`define OFS_IRQ_FLAGS 12'h014
`define OFS_IRQ_CLEAR 12'h018

// converter_control fields
`define CTL_ALIGN_BIT 7
`define CTL_REF_BIT 6
`define CTL_CHAN_HI 3
`define CTL_CHAN_LO 2
`define CTL_GO_BIT 1
`define CTL_PWR_BIT 0
`define CTL_RW_MASK 8'hCF

// analog_select_and_clock fields
`define ASEL_CLK_HI 6
`define ASEL_CLK_LO 4
`define ASEL_PIN_HI 3
`define ASEL_PIN_LO 0
`define ASEL_RW_MASK 8'h7F

// irq bit for conversion done
`define IRQ_DONE_BIT 6

// reset values
`define RST_CONTROL 8'h00
`define RST_ANALOG_SEL 8'h0F
`define RST_IRQ_EN 8'h00
`define RST_IRQ_FLAGS 8'h00

// result width and sar timing
`define RESULT_BITS 10
`define TAD_CNT_W 7

`endif

// ==== design/adc_fmt_pkg.sv ====
package adc_fmt_pkg;
  typedef logic [7:0] byte_reg_t;
  typedef logic [9:0] result_t;
  typedef struct packed {
    byte_reg_t high;
    byte_reg_t low;
  } result_pair_t;
  typedef enum logic [2:0] {
    seq_idle = 3'b001,
    seq_conv = 3'b010,
    seq_done = 3'b100
  } seq_state_t;
endpackage

// ==== design/conv_if.sv ====
`timescale 1ns/1ps
interface conv_link;
  import adc_fmt_pkg::*;
  logic start;
  logic abort;
  logic power;
  logic [2:0] clk_sel;
  logic busy;
  logic done;
  result_t result;
  result_t dac_code;
  logic sample_en;
  logic cmp_high;
  modport ctrl (
    output start, abort, power, clk_sel, cmp_high,
    input busy, done, result, dac_code, sample_en
  );
  modport seq (
    input start, abort, power, clk_sel, cmp_high,
    output busy, done, result, dac_code, sample_en
  );
endinterface

// ==== design/conv_sequencer.sv ====
`timescale 1ns/1ps
`include "adc_fmt_cfg.svh"
module conv_sequencer (
  input wire logic clk,
  input wire logic reset_n,
  conv_link.seq link
);
  import adc_fmt_pkg::*;

  // =========================================
  // conversion clock period
  // =========================================
  function automatic logic [`TAD_CNT_W-1:0] tad_last(input logic [2:0] sel);
    logic [`TAD_CNT_W:0] span;
    span = (`TAD_CNT_W+1)'(1) << sel;
    tad_last = span[`TAD_CNT_W-1:0] - `TAD_CNT_W'(1);
  endfunction

  seq_state_t state;
  logic [`TAD_CNT_W-1:0] tad_cnt;
  logic [3:0] bit_idx;
  logic tad_end;

  assign tad_end = (tad_cnt == tad_last(link.clk_sel));

  // =========================================
  // successive approximation
  // =========================================
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= seq_idle;
      tad_cnt <= '0;
      bit_idx <= 4'h0;
      link.dac_code <= '0;
      link.result <= '0;
      link.done <= 1'b0;
      link.busy <= 1'b0;
    end else begin
      link.done <= 1'b0;
      unique case (state)
        seq_idle: begin
          tad_cnt <= '0;
          if (link.start && link.power) begin
            state <= seq_conv;
            link.busy <= 1'b1;
            bit_idx <= 4'd9;
            link.dac_code <= 10'h200;
          end
        end
        seq_conv: begin
          if (link.abort || !link.power) begin
            state <= seq_idle;
            link.busy <= 1'b0;
          end else if (tad_end) begin
            tad_cnt <= '0;
            if (!link.cmp_high) begin
              link.dac_code[bit_idx] <= 1'b0;
            end
            if (bit_idx == 4'd0) begin
              state <= seq_done;
            end else begin
              link.dac_code[bit_idx - 4'd1] <= 1'b1;
              bit_idx <= bit_idx - 4'd1;
            end
          end else begin
            tad_cnt <= tad_cnt + `TAD_CNT_W'(1);
          end
        end
        seq_done: begin
          link.result <= link.dac_code;
          link.done <= 1'b1;
          link.busy <= 1'b0;
          state <= seq_idle;
        end
      endcase
    end
  end

  // hold capacitor reconnects after conversion, never discharged
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      link.sample_en <= 1'b0;
    end else begin
      link.sample_en <= link.power && (state == seq_idle) && !link.start;
    end
  end
endmodule

// ==== design/adc_result_format_ctrl.sv ====
// Contract
// - left align: result 9..2 into high byte
// - left align: result 1..0 low bits 7..6
// - right align: result 9..8 high bits 1..0
// - right align: result 7..0 into low byte
// - result bytes undefined at power-on, kept otherwise
// - hold capacitor never discharged after conversion
// - go set starts, device clears at end
// - done flag set at end, software clears
`timescale 1ns/1ps
`include "adc_fmt_cfg.svh"
module adc_result_format_ctrl #(
  parameter int ADDR_W = 12,
  parameter int RESULT_W = `RESULT_BITS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmp_high,
  output adc_fmt_pkg::result_t dac_code,
  output logic sample_en,
  output logic [1:0] input_channel_sel,
  output logic ref_source_sel,
  output logic [3:0] analog_pin_sel,
  output logic irq
);
  import adc_fmt_pkg::*;

  // =========================================
  // elaboration checks
  // =========================================
  generate
    if (RESULT_W != 10) begin : g_bad_width
      $error("result width must be 10");
    end
    if (ADDR_W < 5) begin : g_bad_addr
      $error("address width too small for register map");
    end
    if (`TAD_CNT_W < 7) begin : g_bad_tad
      $error("conversion clock counter too narrow");
    end
  endgenerate

  // =========================================
  // result formatting
  // =========================================
  function automatic result_pair_t format_result(input result_t res, input logic align_right);
    result_pair_t pair;
    if (align_right) begin
      pair.high = {6'b00_0000, res[9:8]};
      pair.low = res[7:0];
    end else begin
      pair.high = res[9:2];
      pair.low = {res[1:0], 6'b00_0000};
    end
    format_result = pair;
  endfunction

  // unimplemented and hardware-owned bits are masked out of writes
  function automatic byte_reg_t merge_byte(input byte_reg_t old, input logic [7:0] wdata,
                                           input logic lane, input byte_reg_t mask);
    merge_byte = lane ? ((old & ~mask) | (wdata & mask)) : old;
  endfunction

  // =========================================
  // registers and link
  // =========================================
  conv_link link ();

  byte_reg_t converter_control;
  byte_reg_t analog_select_and_clock;
  byte_reg_t peripheral_irq_enable;
  byte_reg_t peripheral_irq_flags;
  byte_reg_t result_high_byte;
  byte_reg_t result_low_byte;
  result_pair_t formatted;

  logic setup;
  logic access;
  logic wr_en;
  logic rd_en;
  logic lane0;
  logic [ADDR_W-1:0] addr_word;
  logic hit_control;
  logic hit_res_high;
  logic hit_res_low;
  logic hit_analog_sel;
  logic hit_irq_en;
  logic hit_irq_flags;
  logic hit_irq_clear;
  logic hit_any;
  logic bad_access;
  logic go_write_set;
  logic go_write_clear;
  logic conv_done;
  logic result_align_sel;
  logic converter_power_on;
  logic go_flag;
  logic [2:0] conv_clock_sel;
  byte_reg_t next_rdata;
  logic next_irq;

  assign result_align_sel = converter_control[`CTL_ALIGN_BIT];
  assign converter_power_on = converter_control[`CTL_PWR_BIT];
  assign go_flag = converter_control[`CTL_GO_BIT];
  assign conv_clock_sel = analog_select_and_clock[`ASEL_CLK_HI:`ASEL_CLK_LO];

  // =========================================
  // apb decode
  // =========================================
  assign setup = psel && !penable;
  // access ends once pready has been raised
  assign access = psel && penable && !pready;
  // only the low byte lane carries data
  assign lane0 = pstrb[0];
  assign addr_word = {paddr[ADDR_W-1:2], 2'b00};
  assign hit_control = (addr_word == ADDR_W'(`OFS_CONTROL));
  assign hit_res_high = (addr_word == ADDR_W'(`OFS_RES_HIGH));
  assign hit_res_low = (addr_word == ADDR_W'(`OFS_RES_LOW));
  assign hit_analog_sel = (addr_word == ADDR_W'(`OFS_ANALOG_SEL));
  assign hit_irq_en = (addr_word == ADDR_W'(`OFS_IRQ_EN));
  assign hit_irq_flags = (addr_word == ADDR_W'(`OFS_IRQ_FLAGS));
  assign hit_irq_clear = (addr_word == ADDR_W'(`OFS_IRQ_CLEAR));
  assign hit_any = hit_control || hit_res_high || hit_res_low || hit_analog_sel ||
                   hit_irq_en || hit_irq_flags || hit_irq_clear;
  // flags read-only, clear write-only
  assign bad_access = !hit_any || (pwrite && hit_irq_flags) || (!pwrite && hit_irq_clear);
  assign wr_en = access && pwrite && !bad_access;
  assign rd_en = access && !pwrite && !bad_access;

  // an access counts only after its own setup cycle
  logic setup_seen;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      setup_seen <= 1'b0;
    end else begin
      setup_seen <= setup;
    end
  end

  // =========================================
  // register strobes
  // =========================================
  function automatic logic strobe(input logic qualify, input logic seen, input logic hit,
                                  input logic lane);
    strobe = qualify && seen && hit && lane;
  endfunction

  // one strobe per register, high in the access cycle that ends at the edge that raises pready
  logic rd_take;
  logic wr_control;
  logic wr_res_high;
  logic wr_res_low;
  logic wr_analog_sel;
  logic wr_irq_en;
  logic wr_irq_clear;

  assign rd_take = strobe(rd_en, setup_seen, 1'b1, 1'b1);
  assign wr_control = strobe(wr_en, setup_seen, hit_control, 1'b1);
  assign wr_res_high = strobe(wr_en, setup_seen, hit_res_high, lane0);
  assign wr_res_low = strobe(wr_en, setup_seen, hit_res_low, lane0);
  assign wr_analog_sel = strobe(wr_en, setup_seen, hit_analog_sel, 1'b1);
  assign wr_irq_en = strobe(wr_en, setup_seen, hit_irq_en, lane0);
  assign wr_irq_clear = strobe(wr_en, setup_seen, hit_irq_clear, lane0);

  // access completes one cycle after it opens
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= access && setup_seen;
      pslverr <= access && setup_seen && bad_access;
    end
  end

  // read mux
  always_comb begin
    next_rdata = 8'h00;
    unique case (1'b1)
      hit_control: next_rdata = converter_control;
      hit_res_high: next_rdata = result_high_byte;
      hit_res_low: next_rdata = result_low_byte;
      hit_analog_sel: next_rdata = analog_select_and_clock;
      hit_irq_en: next_rdata = peripheral_irq_enable;
      hit_irq_flags: next_rdata = peripheral_irq_flags;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_take) begin
      prdata <= {24'h00_0000, next_rdata};
    end else begin
      // read data stands for the completion cycle only
      prdata <= 32'h0000_0000;
    end
  end

  // =========================================
  // converter control
  // =========================================
  assign go_write_set = wr_control && lane0 &&
                        pwdata[`CTL_GO_BIT] && pwdata[`CTL_PWR_BIT];
  assign go_write_clear = wr_control && lane0 && !pwdata[`CTL_GO_BIT];
  assign conv_done = link.done;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      converter_control <= `RST_CONTROL;
    end else begin
      if (wr_control) begin
        converter_control <= merge_byte(converter_control, pwdata[7:0], lane0,
                                        `CTL_RW_MASK & ~8'h02);
      end
      // software set beats the hardware clear
      if (go_write_set) begin
        converter_control[`CTL_GO_BIT] <= 1'b1;
      end else if (go_write_clear || conv_done) begin
        converter_control[`CTL_GO_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      analog_select_and_clock <= `RST_ANALOG_SEL;
    end else if (wr_analog_sel) begin
      analog_select_and_clock <= merge_byte(analog_select_and_clock, pwdata[7:0], lane0,
                                            `ASEL_RW_MASK);
    end
  end

  // =========================================
  // result bytes
  // =========================================
  // alignment is taken at completion, not at start
  assign formatted = format_result(link.result, result_align_sel);

  // no reset: undefined at power-up, untouched by reset_n
  always_ff @(posedge clk) begin
    if (conv_done) begin
      result_high_byte <= formatted.high;
      result_low_byte <= formatted.low;
    end else begin
      // a completing conversion overrides a software write
      if (wr_res_high) begin
        result_high_byte <= pwdata[7:0];
      end
      if (wr_res_low) begin
        result_low_byte <= pwdata[7:0];
      end
    end
  end

  // =========================================
  // interrupt flags
  // =========================================
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      peripheral_irq_enable <= `RST_IRQ_EN;
    end else if (wr_irq_en) begin
      peripheral_irq_enable <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      peripheral_irq_flags <= `RST_IRQ_FLAGS;
    end else begin
      // write one to clear
      if (wr_irq_clear) begin
        peripheral_irq_flags <= peripheral_irq_flags & ~pwdata[7:0];
      end
      // set wins over a clear in the same cycle
      if (conv_done) begin
        peripheral_irq_flags[`IRQ_DONE_BIT] <= 1'b1;
      end
    end
  end

  always_comb begin
    next_irq = |(peripheral_irq_flags & peripheral_irq_enable);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // =========================================
  // sequencer link
  // =========================================
  // held off while a result lands, so go cannot retrigger
  assign link.start = go_flag && !link.busy && !conv_done;
  // go cleared by software: abort with no result
  assign link.abort = !go_flag;
  assign link.power = converter_power_on;
  assign link.clk_sel = conv_clock_sel;
  assign link.cmp_high = cmp_high;

  conv_sequencer u_seq (
    .clk(clk),
    .reset_n(reset_n),
    .link(link)
  );

  assign dac_code = link.dac_code;
  assign sample_en = link.sample_en;

  // =========================================
  // analog steering outputs
  // =========================================
  // steering follows the registers one cycle late
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      input_channel_sel <= 2'h0;
      ref_source_sel <= 1'b0;
      analog_pin_sel <= 4'hF;
    end else begin
      input_channel_sel <= converter_control[`CTL_CHAN_HI:`CTL_CHAN_LO];
      ref_source_sel <= converter_control[`CTL_REF_BIT];
      analog_pin_sel <= analog_select_and_clock[`ASEL_PIN_HI:`ASEL_PIN_LO];
    end
  end
endmodule

// ==== dv/adc_fmt_chk.sv ====
`timescale 1ns/1ps
module adc_fmt_chk #(
  parameter int ADDR_W = 12,
  parameter int RESULT_W = 10
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire adc_fmt_pkg::result_t dac_code,
  input wire logic sample_en,
  input wire logic [1:0] input_channel_sel,
  input wire logic ref_source_sel,
  input wire logic [3:0] analog_pin_sel,
  input wire logic irq
);
  import adc_fmt_pkg::*;
  logic [ADDR_W-3:0] idx;
  assign idx = paddr[ADDR_W-1:2];
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========
  // bus answer
  ready_timing_a: assert property (psel && !penable |-> ##2 pready)
    else $error("pready late after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0000_0000)
    else $error("prdata not zero outside read");
  rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("prdata upper bits set");
  refuse_err_a: assert property (pready && (idx >= 7 || (pwrite && idx == 5)
    || (!pwrite && idx == 6)) |-> pslverr)
    else $error("refused access not flagged");
  mapped_ok_a: assert property (pready && idx < 5 |-> !pslverr)
    else $error("mapped access flagged");
  // ==========
  // converter
  reset_state_a: assert property ($rose(reset_n) |-> analog_pin_sel == 4'hf && !irq
    && input_channel_sel == 2'h0 && !ref_source_sel)
    else $error("outputs wrong after reset");
  first_trial_a: assert property ($fell(sample_en) |-> dac_code == 10'h200)
    else $error("first trial code wrong");
  conv_hold_a: assert property ($fell(sample_en) |-> !sample_en [*8])
    else $error("sampling resumed mid conversion");
  irq_clear_a: assert property ($fell(irq) |-> $past(pready && pwrite, 1)
    || $past(pready && pwrite, 2))
    else $error("irq dropped without a write");
endmodule
bind adc_result_format_ctrl adc_fmt_chk #(.ADDR_W(ADDR_W), .RESULT_W(RESULT_W)) u_chk (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .dac_code(dac_code), .sample_en(sample_en), .input_channel_sel(input_channel_sel),
  .ref_source_sel(ref_source_sel), .analog_pin_sel(analog_pin_sel), .irq(irq));

// ==== dv/conv_far_side.sv ====
`timescale 1ns/1ps
module conv_far_side (
  input wire logic clk,
  input wire logic sample_en,
  input wire adc_fmt_pkg::result_t dac_code,
  input wire adc_fmt_pkg::result_t vin,
  output logic cmp_high
);
  import adc_fmt_pkg::*;
  result_t held;
  // hold capacitor tracks only while the switch is closed, never discharged
  always @(posedge clk) begin
    if (sample_en) begin
      held <= vin;
    end
  end
  assign cmp_high = held >= dac_code;
endmodule

// ==== dv/adc_result_format_ctrl_tb.sv ====
`timescale 1ns/1ps
`include "adc_fmt_cfg.svh"
module adc_result_format_ctrl_tb;
  import adc_fmt_pkg::*;
  localparam int ACQ = 500;
  logic clk, reset_n, psel, penable, pwrite, cmp_high, sample_en, ref_source_sel, irq;
  logic pready, pslverr, e, al;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, analog_pin_sel;
  logic [1:0] input_channel_sel, ch;
  logic [7:0] q, ctl, asel;
  logic [15:0] seed;
  result_t dac_code, vin;
  result_pair_t ep;
  int failures, compares, n;

  adc_result_format_ctrl u_dut (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_high(cmp_high),
    .dac_code(dac_code), .sample_en(sample_en), .input_channel_sel(input_channel_sel),
    .ref_source_sel(ref_source_sel), .analog_pin_sel(analog_pin_sel), .irq(irq));
  conv_far_side u_far (.clk(clk), .sample_en(sample_en), .dac_code(dac_code), .vin(vin),
    .cmp_high(cmp_high));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic result_pair_t fmt(input logic right, input result_t r);
    return right ? {6'h00, r} : {r, 6'h00};
  endfunction
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task conclude();
    if (failures == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========
  // bus master
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk(q, x);
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
    chk_bit(e, 1'b0);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    conclude();
  end
  // ==========
  // main sequence
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    vin = 10'h000;
    seed = 16'h005b;
    failures = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    rd(`OFS_CONTROL, `RST_CONTROL);
    rd(`OFS_ANALOG_SEL, `RST_ANALOG_SEL);
    rd(`OFS_IRQ_EN, `RST_IRQ_EN);
    rd(`OFS_IRQ_FLAGS, `RST_IRQ_FLAGS);
    apb(1'b0, 12'h01c, 8'h00);
    chk_bit(e, 1'b1);
    apb(1'b1, `OFS_IRQ_FLAGS, 8'h40);
    chk_bit(e, 1'b1);
    apb(1'b0, `OFS_IRQ_CLEAR, 8'h00);
    chk_bit(e, 1'b1);
    wr(`OFS_RES_HIGH, 8'ha5);
    wr(`OFS_RES_LOW, 8'h5a);
    pstrb <= 4'h0;
    wr(`OFS_RES_HIGH, 8'h00);
    pstrb <= 4'hf;
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rd(`OFS_RES_HIGH, 8'ha5);
    rd(`OFS_RES_LOW, 8'h5a);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      vin <= (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : (i == 2) ? 10'h200 : seed[9:0];
      al = i[0];
      ch = i[2:1];
      ctl = {al, i[1], 2'b00, ch, 2'b01};
      asel = {1'b0, (i == 7) ? 3'h1 : 3'h0, seed[13:10]};
      wr(`OFS_IRQ_EN, (i == 5) ? 8'h00 : 8'h40);
      wr(`OFS_ANALOG_SEL, asel);
      wr(`OFS_CONTROL, ctl);
      repeat (ACQ) @(posedge clk);
      chk({analog_pin_sel, 1'b0, ref_source_sel, input_channel_sel}, {asel[3:0], 1'b0, i[1], ch});
      wr(`OFS_CONTROL, ctl | 8'h02);
      n = 0;
      do begin
        apb(1'b0, `OFS_CONTROL, 8'h00);
        n++;
      end while (q[1] !== 1'b0 && n < 50);
      chk(q, ctl);
      rd(`OFS_IRQ_FLAGS, 8'h40);
      chk_bit(irq, i != 5);
      ep = fmt(al, vin);
      rd(`OFS_RES_HIGH, ep.high);
      rd(`OFS_RES_LOW, ep.low);
      wr(`OFS_IRQ_CLEAR, 8'h40);
      rd(`OFS_IRQ_FLAGS, 8'h00);
      chk_bit(irq, 1'b0);
    end
    conclude();
  end
endmodule
